// ---- src/ebcp_pkg.sv ----
// shared constants and types for the external bus cycle phaser
// assumes a 100 MHz cpu clock and a 32-bit apb register port
package ebcp_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [11:0] CFG_BASE = 12'h000;
    localparam logic [11:0] STAT_OFS = 12'h040;
    localparam logic [11:0] RDATA_OFS = 12'h044;

    // ****************************************
    // timing field layout and reset value
    // ****************************************
    localparam int CFG_W = 14;
    localparam logic [CFG_W-1:0] CFG_RST = 14'h07C0;
    localparam int CNT_W = 6;
    localparam int CLK_MHZ = 100;
    localparam int CPU_CLOCK_PERIOD_NS = 10;
    // one phase unit is one cpu clock period
    localparam int PHASE_UNIT_CYC = CPU_CLOCK_PERIOD_NS * CLK_MHZ / 1000;

    typedef struct packed {
        logic separateAddressDataModeN;
        logic [1:0] holdPhaseLen;
        logic [4:0] accessPhaseLenM1;
        logic writeSetupTristatePhaseLen;
        logic [1:0] commandDelayPhaseLen;
        logic [1:0] windowChangeExt;
        logic addressSetupTwo;
    } timing_s;

    typedef struct packed {
        logic [23:0] addr;
        logic [15:0] dataOut;
        logic dataOe;
        logic rdN;
        logic wrN;
        logic ale;
        logic highByteSelectN;
    } pins_s;

    typedef struct packed {
        logic [23:0] addr;
        logic [15:0] wdata;
        logic write;
        logic highByte;
    } req_s;

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_ADDR,
        PH_CMD,
        PH_WSET,
        PH_ACC,
        PH_HOLD
    } phase_e;

endpackage : ebcp_pkg

// ---- src/external_bus_cycle_phaser.sv ----
// external bus cycle sequencer with per chip-select timing registers
// assumes a cpu-side request port and an apb master for the registers
`timescale 1ns/1ps

module external_bus_cycle_phaser #(
    parameter int NUM_CS = 4
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic reqValid,
    output logic reqReady,
    input wire ebcp_pkg::req_s req,
    input wire logic [$clog2(NUM_CS)-1:0] reqSel,
    output logic rspValid,
    output logic [15:0] rspData,
    output ebcp_pkg::pins_s busPins,
    output logic [NUM_CS-1:0] chipSelectN,
    input wire logic [15:0] busDataIn
);

    // ****************************************
    // reset release
    // ****************************************
    logic rstMeta_r;
    logic rstN;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rstMeta_r <= 1'b0;
            rstN <= 1'b0;
        end else begin
            rstMeta_r <= 1'b1;
            rstN <= rstMeta_r;
        end
    end

    // ****************************************
    // apb register file
    // ****************************************
    ebcp_pkg::timing_s cfg_r [NUM_CS];
    logic [31:0] prdata_r;
    logic [31:0] rdNxt;
    logic hitNxt;
    logic [3:0] cfgIdx;
    logic cfgHit;

    ebcp_pkg::phase_e state_r;
    ebcp_pkg::phase_e stateNxt;
    logic [$clog2(NUM_CS)-1:0] lastSel_r;
    logic [15:0] rspData_r;

    assign cfgIdx = paddr[5:2];
    assign cfgHit = paddr[11:6] == ebcp_pkg::CFG_BASE[11:6] && paddr[1:0] == 2'b00
        && {28'h0, cfgIdx} < NUM_CS;

    always_comb begin
        rdNxt = 32'h0000_0000;
        hitNxt = 1'b1;
        if (cfgHit) begin
            rdNxt = {{(32 - ebcp_pkg::CFG_W){1'b0}}, cfg_r[cfgIdx[$clog2(NUM_CS)-1:0]]};
        end else if (paddr == ebcp_pkg::STAT_OFS) begin
            rdNxt = {24'h00_0000, 1'b0, lastSel_r[$clog2(NUM_CS)-1:0] != 0,
                3'(state_r), 2'b00, state_r != ebcp_pkg::PH_IDLE};
        end else if (paddr == ebcp_pkg::RDATA_OFS) begin
            rdNxt = {16'h0000, rspData_r};
        end else begin
            hitNxt = 1'b0;
        end
    end

    // read data is loaded in the setup cycle so the access phase answers at once
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            prdata_r <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata_r <= pwrite ? 32'h0000_0000 : rdNxt;
            pslverr <= !hitNxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = 1'b1;

    // writes to a busy select only reach the next access, the live one uses a copy
    generate
        for (genvar i = 0; i < NUM_CS; i++) begin : g_cfg
            always_ff @(posedge clk_sys or negedge rstN) begin
                if (!rstN) begin
                    cfg_r[i] <= ebcp_pkg::CFG_RST;
                end else if (psel && penable && pwrite && cfgHit && cfgIdx == i) begin
                    cfg_r[i] <= pwdata[ebcp_pkg::CFG_W-1:0];
                end
            end
        end
    endgenerate

    // ****************************************
    // phase sequencer
    // ****************************************
    ebcp_pkg::timing_s cur_r;
    ebcp_pkg::req_s reqHold_r;
    logic [2:0] addrLen_r;
    logic firstDone_r;
    logic [ebcp_pkg::CNT_W-1:0] cnt_r;
    logic [ebcp_pkg::CNT_W-1:0] phLen;
    logic lastCyc;
    logic accept;
    logic winChange;

    assign reqReady = state_r == ebcp_pkg::PH_IDLE;
    assign accept = reqValid && reqReady;
    assign winChange = !firstDone_r || reqSel != lastSel_r;

    always_comb begin
        unique case (state_r)
            ebcp_pkg::PH_ADDR: phLen = {3'b000, addrLen_r};
            ebcp_pkg::PH_CMD: phLen = {4'h0, cur_r.commandDelayPhaseLen};
            ebcp_pkg::PH_WSET: phLen = 6'h01;
            ebcp_pkg::PH_ACC: phLen = {1'b0, cur_r.accessPhaseLenM1} + 6'h01;
            ebcp_pkg::PH_HOLD: phLen = {4'h0, cur_r.holdPhaseLen};
            default: phLen = 6'h01;
        endcase
    end

    assign lastCyc = state_r != ebcp_pkg::PH_IDLE && cnt_r == phLen - 6'h01;

    // zero-length phases are skipped, the order itself never changes
    always_comb begin
        stateNxt = state_r;
        unique case (state_r)
            ebcp_pkg::PH_IDLE: if (reqValid) stateNxt = ebcp_pkg::PH_ADDR;
            ebcp_pkg::PH_ADDR: if (lastCyc) begin
                if (cur_r.commandDelayPhaseLen != 2'b00) stateNxt = ebcp_pkg::PH_CMD;
                else if (cur_r.writeSetupTristatePhaseLen) stateNxt = ebcp_pkg::PH_WSET;
                else stateNxt = ebcp_pkg::PH_ACC;
            end
            ebcp_pkg::PH_CMD: if (lastCyc) begin
                stateNxt = cur_r.writeSetupTristatePhaseLen ? ebcp_pkg::PH_WSET
                    : ebcp_pkg::PH_ACC;
            end
            ebcp_pkg::PH_WSET: if (lastCyc) stateNxt = ebcp_pkg::PH_ACC;
            ebcp_pkg::PH_ACC: if (lastCyc) begin
                stateNxt = cur_r.holdPhaseLen != 2'b00 ? ebcp_pkg::PH_HOLD
                    : ebcp_pkg::PH_IDLE;
            end
            ebcp_pkg::PH_HOLD: if (lastCyc) stateNxt = ebcp_pkg::PH_IDLE;
            default: stateNxt = ebcp_pkg::PH_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            state_r <= ebcp_pkg::PH_IDLE;
            cnt_r <= 6'h00;
        end else begin
            state_r <= stateNxt;
            cnt_r <= stateNxt != state_r ? 6'h00 : cnt_r + 6'h01;
        end
    end

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            cur_r <= ebcp_pkg::CFG_RST;
            reqHold_r <= '0;
            addrLen_r <= 3'h1;
            lastSel_r <= '0;
            firstDone_r <= 1'b0;
        end else if (accept) begin
            cur_r <= cfg_r[reqSel];
            reqHold_r <= req;
            addrLen_r <= 3'h1 + {2'b00, cfg_r[reqSel].addressSetupTwo}
                + (winChange ? {1'b0, cfg_r[reqSel].windowChangeExt} : 3'h0);
            lastSel_r <= reqSel;
            firstDone_r <= 1'b1;
        end
    end

    // ****************************************
    // read capture and completion
    // ****************************************
    // sampled on the edge that lifts the read strobe, later address moves are harmless
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            rspData_r <= 16'h0000;
            rspValid <= 1'b0;
        end else begin
            rspValid <= state_r == ebcp_pkg::PH_ACC && lastCyc;
            if (state_r == ebcp_pkg::PH_ACC && lastCyc && !reqHold_r.write) begin
                rspData_r <= busDataIn;
            end
        end
    end

    assign rspData = rspData_r;

    // ****************************************
    // pin drivers
    // ****************************************
    ebcp_pkg::req_s src;
    ebcp_pkg::timing_s srcCfg;
    logic [$clog2(NUM_CS)-1:0] srcSel;
    logic active;
    logic muxAddr;

    assign src = accept ? req : reqHold_r;
    assign srcCfg = accept ? cfg_r[reqSel] : cur_r;
    assign srcSel = accept ? reqSel : lastSel_r;
    assign active = stateNxt != ebcp_pkg::PH_IDLE;
    assign muxAddr = srcCfg.separateAddressDataModeN
        && (stateNxt == ebcp_pkg::PH_ADDR || stateNxt == ebcp_pkg::PH_CMD);

    // pins follow the next phase so they switch on the same edge as the state
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            busPins <= '{addr: 24'h00_0000, dataOut: 16'h0000, dataOe: 1'b0, rdN: 1'b1,
                wrN: 1'b1, ale: 1'b0, highByteSelectN: 1'b1};
            chipSelectN <= '1;
        end else begin
            if (active) begin
                busPins.addr <= src.addr;
                busPins.highByteSelectN <= !src.highByte;
            end
            busPins.ale <= stateNxt == ebcp_pkg::PH_ADDR;
            busPins.rdN <= !(stateNxt == ebcp_pkg::PH_ACC && !src.write);
            busPins.wrN <= !(stateNxt == ebcp_pkg::PH_ACC && src.write);
            busPins.dataOut <= muxAddr ? src.addr[15:0] : src.wdata;
            busPins.dataOe <= muxAddr || (src.write && (stateNxt == ebcp_pkg::PH_WSET
                || stateNxt == ebcp_pkg::PH_ACC || stateNxt == ebcp_pkg::PH_HOLD));
            for (int i = 0; i < NUM_CS; i++) begin
                chipSelectN[i] <= !(active && srcSel == i);
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    logic [ebcp_pkg::CNT_W-1:0] stay_r;

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) stay_r <= 6'h00;
        else stay_r <= stateNxt != state_r ? 6'h01 : stay_r + 6'h01;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstN);

    property p_order;
        state_r == ebcp_pkg::PH_ACC && stateNxt != ebcp_pkg::PH_ACC
            |=> state_r inside {ebcp_pkg::PH_HOLD, ebcp_pkg::PH_IDLE};
    endproperty
    a_order: assert property (p_order) else $error("access not followed by hold");

    property p_cfg_copy;
        accept |=> cur_r == $past(cfg_r[reqSel]);
    endproperty
    a_cfg_copy: assert property (p_cfg_copy) else $error("timing not taken from select");

    property p_setup_len;
        state_r == ebcp_pkg::PH_ADDR && stateNxt != ebcp_pkg::PH_ADDR
            |-> stay_r == {3'b000, addrLen_r} && stay_r >= 6'h01 && stay_r <= 6'h05;
    endproperty
    a_setup_len: assert property (p_setup_len) else $error("address setup length wrong");

    property p_wset_len;
        $rose(state_r == ebcp_pkg::PH_WSET) |=> state_r == ebcp_pkg::PH_ACC;
    endproperty
    a_wset_len: assert property (p_wset_len) else $error("write setup not one period");

    property p_hold_len;
        state_r == ebcp_pkg::PH_HOLD && stateNxt != ebcp_pkg::PH_HOLD
            |-> stay_r == {4'h0, cur_r.holdPhaseLen} && busPins.addr == reqHold_r.addr;
    endproperty
    a_hold_len: assert property (p_hold_len) else $error("hold length wrong");

    property p_read_capture;
        $rose(busPins.rdN) |-> rspData_r == $past(busDataIn) && rspValid;
    endproperty
    a_read_capture: assert property (p_read_capture) else $error("read data not captured");

    property p_access_len;
        state_r == ebcp_pkg::PH_ACC && stateNxt != ebcp_pkg::PH_ACC
            |-> stay_r == {1'b0, cur_r.accessPhaseLenM1} + 6'h01;
    endproperty
    a_access_len: assert property (p_access_len) else $error("access length wrong");

    c_read: cover property ($rose(busPins.rdN));
    c_write_hold: cover property (!busPins.wrN ##1 state_r == ebcp_pkg::PH_HOLD);
    c_long_setup: cover property (state_r == ebcp_pkg::PH_ADDR && stay_r == 6'h05);

endmodule : external_bus_cycle_phaser

// ---- test/external_bus_memory_model.sv ----
// behavioural memory on the far side of the external bus
// assumes the phaser drives address, strobes and selects as registers
`timescale 1ns/1ps

module external_bus_memory_model #(
    parameter int NUM_CS = 4
) (
    input wire logic clk_sys,
    input wire ebcp_pkg::pins_s busPins,
    input wire logic [NUM_CS-1:0] chipSelectN,
    output logic [15:0] busDataIn
);
    // ****************************************
    // storage
    // ****************************************
    logic [15:0] mem [0:15];
    logic [15:0] lastOut = 16'h0000;
    logic picked;

    assign picked = ~(&chipSelectN);

    always @(posedge clk_sys) begin
        if (!busPins.wrN && busPins.dataOe && picked) begin
            mem[busPins.addr[3:0]] <= busPins.dataOut;
        end
    end

    // ****************************************
    // read drive
    // ****************************************
    // data stands while the read strobe is low, then the bus is let go
    always @(posedge clk_sys) begin
        if (!busPins.rdN && picked) begin
            lastOut <= mem[busPins.addr[3:0]];
        end
    end
    // released bus shows the inverse, so a late capture is caught
    assign busDataIn = (!busPins.rdN && picked) ? mem[busPins.addr[3:0]] : ~lastOut;

endmodule : external_bus_memory_model

// ---- test/external_bus_cycle_phaser_test.sv ----
// self-checking bench: apb set-up of timing words, then bus accesses
// assumes the memory model answers on the external bus side
`timescale 1ns/1ps

module external_bus_cycle_phaser_test;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic reqValid = 1'b0;
    logic reqReady;
    ebcp_pkg::req_s req = '0;
    logic [1:0] reqSel = 2'h0;
    logic rspValid;
    logic [15:0] rspData;
    ebcp_pkg::pins_s busPins;
    logic [3:0] chipSelectN;
    logic [15:0] busDataIn;
    int bad_count = 0;
    int n_tests = 0;
    int prevSel = -1;
    // one row per select; together they cover every extension value
    logic [13:0] cfgTab [4] = '{14'h2000, 14'h1FFF, 14'h290C, 14'h11F3};

    always #5 clk_sys = ~clk_sys;

    external_bus_cycle_phaser #(.NUM_CS(4)) DUT (
        .clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .reqValid(reqValid), .reqReady(reqReady),
        .req(req), .reqSel(reqSel), .rspValid(rspValid), .rspData(rspData),
        .busPins(busPins), .chipSelectN(chipSelectN), .busDataIn(busDataIn)
    );

    external_bus_memory_model #(.NUM_CS(4)) memModel (
        .clk_sys(clk_sys), .busPins(busPins), .chipSelectN(chipSelectN),
        .busDataIn(busDataIn)
    );

    // ****************************************
    // checking and closing
    // ****************************************
    task complete_run;
        $display("tests %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, seen);
            bad_count++;
        end
    endtask : check

    task timed_out;
        $display("Error wait limit expected answer seen none");
        bad_count++;
        complete_run;
    endtask : timed_out

    // ****************************************
    // bus tasks
    // ****************************************
    // entered just after a rising edge; ends one idle edge after release
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
             output logic [31:0] rd, output logic err);
        int i;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_sys);
            if (pready === 1'b1) break;
        end
        if (i == 20) timed_out;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb

    // one cpu access; counts setup and strobe phases as seen at the pins, hold from reqReady
    task access(input logic [1:0] sel, input logic wr, input logic [15:0] wd,
                input logic [13:0] cfg);
        int n, nAle, nCmd, nHold, setup;
        n = 0;
        nAle = 0;
        nCmd = 0;
        nHold = 0;
        setup = 1 + cfg[0] + ((sel != prevSel) ? cfg[2:1] : 0);
        reqValid <= 1'b1;
        req <= '{addr: {22'h000000, sel}, wdata: wd, write: wr, highByte: 1'b1};
        reqSel <= sel;
        @(posedge clk_sys);
        reqValid <= 1'b0;
        do begin
            @(posedge clk_sys);
            n++;
            nAle += (busPins.ale === 1'b1);
            nCmd += ((wr ? busPins.wrN : busPins.rdN) === 1'b0);
        end while (rspValid !== 1'b1 && n < 100);
        if (n == 100) timed_out;
        if (!wr) check("read data", rspData, wd);
        while (reqReady !== 1'b1 && nHold < 10) begin
            nHold++;
            @(posedge clk_sys);
        end
        if (nHold == 10) timed_out;
        check("cycle length", n, setup + cfg[4:3] + cfg[5] + cfg[10:6] + 2);
        check("address setup", nAle, setup);
        check("strobe length", nCmd, cfg[10:6] + 1);
        check("hold length", nHold, cfg[12:11]);
        // pins keep the last address once idle, selects are all let go
        check("address pins", busPins.addr, {22'h000000, sel});
        check("high byte select", busPins.highByteSelectN, 1'b0);
        check("select released", chipSelectN, 4'hF);
        prevSel = sel;
    endtask : access

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        logic [31:0] rd;
        logic err;
        repeat (3) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        for (int k = 0; k < 4; k++) begin
            apb(1'b0, ebcp_pkg::CFG_BASE + 12'(4 * k), 32'h00000000, rd, err);
            check("timing reset value", rd, 32'h000007C0);
        end
        apb(1'b1, 12'h100, 32'hFFFFFFFF, rd, err);
        apb(1'b0, 12'h100, 32'h00000000, rd, err);
        check("unmapped error", err, 1'b1);
        check("unmapped data", rd, 32'h00000000);
        $display("test register reset done");
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, ebcp_pkg::CFG_BASE + 12'(4 * k), {18'h00000, cfgTab[k]}, rd, err);
            apb(1'b0, ebcp_pkg::CFG_BASE + 12'(4 * k), 32'h00000000, rd, err);
            check("timing readback", rd, {18'h00000, cfgTab[k]});
        end
        $display("test timing words done");
        // change select every second access so every window change extension is exercised
        for (int k = 0; k < 4; k++) begin
            access(2'(k), 1'b1, 16'hA5C0 + 16'(k), cfgTab[k]);
            access(2'(k), 1'b0, 16'hA5C0 + 16'(k), cfgTab[k]);
        end
        $display("test bus cycles done");
        // status is read only: a write is taken without error and changes nothing
        apb(1'b1, ebcp_pkg::STAT_OFS, 32'hFFFFFFFF, rd, err);
        check("status write error", err, 1'b0);
        apb(1'b0, ebcp_pkg::STAT_OFS, 32'h00000000, rd, err);
        check("status idle", rd, 32'h00000040);
        apb(1'b0, ebcp_pkg::RDATA_OFS, 32'h00000000, rd, err);
        check("last read data", rd, 32'h0000A5C3);
        $display("test status registers done");
        complete_run;
    end

endmodule : external_bus_cycle_phaser_test
